// [ldesr_host.sv]
`timescale 1ns/1ps
module ldesr_host (
    // serial link toward the device
    output logic      o_spi_sclk,
    output logic      o_spi_cs_n,
    output logic      o_spi_sdi,
    input  wire logic i_spi_sdo
);
    initial
    begin
        o_spi_sclk = 1'b0;
        o_spi_cs_n = 1'b1;
        o_spi_sdi  = 1'b0;
    end

    // ----
    // one frame, msb first; clock stands still outside frames
    // ----
    task automatic xfer(input int nbits, input logic [23:0] w, output logic [23:0] rd);
        rd = 24'h000000;
        #7;
        o_spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            o_spi_sdi = w[23 - (i % 24)];
            #15;
            o_spi_sclk = 1'b1;
            rd = {rd[22:0], i_spi_sdo};
            #15;
            o_spi_sclk = 1'b0;
        end
        #15;
        o_spi_cs_n = 1'b1;
        // released line flips so a stale bit is never mistaken for data
        o_spi_sdi = ~o_spi_sdi;
        #100;
    endtask
endmodule

// [ldesr_pkg.sv]
package ldesr_pkg;

    // ----------------------------------------------------------------
    // clocking and timing
    // ----------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ         = 100_000_000;
    localparam int unsigned TIMEOUT_STEP_MS     = 50;
    localparam int unsigned TIMEOUT_STEP_CYCLES = CORE_CLK_HZ / 1000 * TIMEOUT_STEP_MS;
    localparam int unsigned SYNC_STAGES         = 2;

    // ----------------------------------------------------------------
    // serial frame layout
    // ----------------------------------------------------------------
    localparam int unsigned FRAME_BITS    = 24;
    localparam int unsigned CMD_READ_BIT  = 23;
    localparam int unsigned ADDR_MSB      = 22;
    localparam int unsigned ADDR_LSB      = 16;
    localparam int unsigned DATA_MSB      = 15;
    localparam logic [4:0]  LAST_BIT_IDX  = 5'h17;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_LOWER_ERROR = 7'h06;
    localparam logic [6:0] ADDR_UPPER_ERROR = 7'h07;
    localparam logic [6:0] ADDR_SOFT_RESET  = 7'h08;
    localparam logic [6:0] ADDR_STATUS      = 7'h09;
    localparam logic [6:0] ADDR_STATUS_ALT  = 7'h7F;

    // ----------------------------------------------------------------
    // reset values, limits and keys
    // ----------------------------------------------------------------
    localparam logic [15:0] LOWER_ERROR_RESET = 16'h2400;
    localparam logic [15:0] UPPER_ERROR_RESET = 16'hE800;
    localparam logic [7:0]  LOWER_ERROR_MAX   = 8'h80;
    localparam logic [7:0]  UPPER_ERROR_MIN   = 8'h80;
    localparam logic [7:0]  ERROR_LOW_BYTE    = 8'h00;
    localparam logic [15:0] SOFT_RESET_KEY    = 16'hC33C;
    localparam logic [2:0]  RESOLUTION_CODE   = 3'h7;

    // ----------------------------------------------------------------
    // status bit positions
    // ----------------------------------------------------------------
    localparam int unsigned ST_RES_MSB      = 7;
    localparam int unsigned ST_RES_LSB      = 5;
    localparam int unsigned ST_STRAP        = 4;
    localparam int unsigned ST_FRAME_ERR    = 3;
    localparam int unsigned ST_TIMEOUT      = 2;
    localparam int unsigned ST_LOOP_STICKY  = 1;
    localparam int unsigned ST_LOOP_LIVE    = 0;

endpackage

// [ldesr_props.sv]
`timescale 1ns/1ps
module ldesr_props (
    // core clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_reset_n,
    // serial link
    input wire logic        i_spi_sclk,
    input wire logic        i_spi_cs_n,
    input wire logic        i_spi_sdi,
    input wire logic        o_spi_sdo,
    input wire logic        o_spi_sdo_oe_n,
    // pins and converter path
    input wire logic        i_error_level_strap,
    input wire logic        i_loop_fault_live,
    input wire logic [15:0] i_output_code,
    input wire logic        i_high_error_select,
    input wire logic        i_low_error_select,
    input wire logic [2:0]  i_timeout_setting,
    input wire logic [15:0] o_converter_code,
    input wire logic        o_serial_timeout,
    input wire logic        o_soft_reset
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ----
    // converter code selection
    // ----
    hi_code_a: assert property (
        i_high_error_select |=> o_converter_code[7:0] == 8'h00
            && o_converter_code[15:8] >= 8'h80)
        else $error("high error code malformed");
    lo_code_a: assert property (
        !i_high_error_select && i_low_error_select |=> o_converter_code[7:0] == 8'h00
            && o_converter_code[15:8] <= 8'h80)
        else $error("low error code malformed");
    pass_code_a: assert property (
        !i_high_error_select && !i_low_error_select
            |=> o_converter_code == $past(i_output_code))
        else $error("normal code not passed through");
    // no frame end in sight, so the stored level cannot move
    hold_code_a: assert property (
        (i_high_error_select && i_spi_cs_n)[*8] |=> $stable(o_converter_code))
        else $error("error level changed without a write");

    // ----
    // soft reset and timeout
    // ----
    sequence s_soft_fired;
        o_soft_reset ##1 i_high_error_select[*2];
    endsequence
    soft_pulse_a: assert property (
        o_soft_reset |-> i_spi_cs_n ##1 !o_soft_reset)
        else $error("soft reset pulse malformed");
    soft_default_a: assert property (
        s_soft_fired |=> o_converter_code == 16'hE800)
        else $error("upper level not restored");
    reset_val_a: assert property (
        $rose(i_reset_n) |-> !o_serial_timeout && !o_soft_reset && o_converter_code == 16'h0000)
        else $error("outputs not cleared by reset");
    tmo_clear_a: assert property (
        $fell(o_serial_timeout) |-> $past(i_spi_cs_n, 2) && i_spi_cs_n)
        else $error("timeout cleared outside frame end");
    oe_follow_a: assert property (
        o_spi_sdo_oe_n == i_spi_cs_n)
        else $error("output enable not following select");
endmodule

bind ldesr_top ldesr_props chk_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_spi_sclk(i_spi_sclk),
    .i_spi_cs_n(i_spi_cs_n), .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo),
    .o_spi_sdo_oe_n(o_spi_sdo_oe_n), .i_error_level_strap(i_error_level_strap),
    .i_loop_fault_live(i_loop_fault_live), .i_output_code(i_output_code),
    .i_high_error_select(i_high_error_select), .i_low_error_select(i_low_error_select),
    .i_timeout_setting(i_timeout_setting), .o_converter_code(o_converter_code),
    .o_serial_timeout(o_serial_timeout), .o_soft_reset(o_soft_reset));

// [ldesr_top.sv]
`timescale 1ns/1ps
// Behaviour
// - error-level select drives converter with error byte high, zero low byte.
// - upper error writes below mid-scale are dropped, old value kept.
// - upper error register resets to 0xE800 at address 0x07.
// - unlock pattern then idle write restores all writable registers.
// - status reads identically at address 0x09 and 0x7F.
// - status bits 7:5 always read 111.
// - status bit 4 mirrors the error-level strap pin.
// - write whose clock count is not a multiple of 24 sets frame error.
// - status read clears frame error; otherwise it holds.
// - timeout flag rises when no correctly framed write, to any address, arrives within the interval.
// - correctly framed write to a valid address clears timeout flag.
// - loop fault sticky bit latches faults, clears on status read.
// - status bit 0 shows live loop fault, unlatched.
// - timeout interval is (setting + 1) times 50 ms.
// - every correctly framed write, idle write included, restarts the timeout timer.
// - lower error writes above mid-scale are dropped, old value kept.
module ldesr_top #(
    parameter int unsigned P_STEP_CYCLES = ldesr_pkg::TIMEOUT_STEP_CYCLES,
    parameter logic [6:0]  P_IDLE_ADDR   = 7'h02,
    parameter logic [6:0]  P_MAX_ADDR    = 7'h09
) (
    // core clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // serial link
    input  wire logic        i_spi_sclk,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_sdi,
    output logic             o_spi_sdo,
    output logic             o_spi_sdo_oe_n,
    // pins and analog status
    input  wire logic        i_error_level_strap,
    input  wire logic        i_loop_fault_live,
    // converter path
    input  wire logic [15:0] i_output_code,
    input  wire logic        i_high_error_select,
    input  wire logic        i_low_error_select,
    input  wire logic [2:0]  i_timeout_setting,
    output logic [15:0]      o_converter_code,
    output logic             o_serial_timeout,
    output logic             o_soft_reset
);

    // ----------------------------------------------------------------
    // link domain: shift in, count clocks, shift out
    // ----------------------------------------------------------------
    logic [23:0] link_shift;
    logic [4:0]  link_bit_idx;
    logic        link_word_seen;
    logic        link_active;
    logic        link_sdo;
    logic        link_frame_tog;
    logic [23:0] read_word;

    // active drops asynchronously when the frame ends, so the next frame
    // restarts counting on its own first edge without needing a free clock
    always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n)
    begin
        if (i_spi_cs_n)
            link_active <= 1'b0;
        else
            link_active <= 1'b1;
    end

    always_ff @(posedge i_spi_sclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            link_shift     <= 24'h000000;
            link_bit_idx   <= 5'h00;
            link_word_seen <= 1'b0;
            link_frame_tog <= 1'b0;
        end
        else
        begin
            link_shift <= {link_shift[22:0], i_spi_sdi};
            if (link_active)
            begin
                if (link_bit_idx == ldesr_pkg::LAST_BIT_IDX)
                begin
                    link_bit_idx   <= 5'h00;
                    link_word_seen <= 1'b1;
                end
                else
                begin
                    link_bit_idx <= link_bit_idx + 5'h01;
                end
            end
            else
            begin
                // first edge of a frame; the toggle lets the core tell a
                // clocked frame from a bare chip-select blip
                link_bit_idx   <= 5'h01;
                link_word_seen <= 1'b0;
                link_frame_tog <= ~link_frame_tog;
            end
        end
    end

    // read_word is only changed by the core while chip select is high,
    // so it is static whenever the link samples it
    always_ff @(negedge i_spi_sclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            link_sdo <= 1'b0;
        else if (link_bit_idx == 5'h00)
            link_sdo <= read_word[ldesr_pkg::CMD_READ_BIT];
        else
            link_sdo <= read_word[ldesr_pkg::LAST_BIT_IDX - link_bit_idx];
    end

    assign o_spi_sdo      = link_active ? link_sdo : read_word[ldesr_pkg::CMD_READ_BIT];
    assign o_spi_sdo_oe_n = i_spi_cs_n;

    // ----------------------------------------------------------------
    // synchronisers into the core domain
    // ----------------------------------------------------------------
    logic [1:0] cs_sync;
    logic [1:0] strap_sync;
    logic [1:0] fault_sync;
    logic       cs_prev;

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cs_sync    <= 2'h3;
            strap_sync <= 2'h0;
            fault_sync <= 2'h0;
            cs_prev    <= 1'b1;
        end
        else
        begin
            cs_sync    <= {cs_sync[0], i_spi_cs_n};
            strap_sync <= {strap_sync[0], i_error_level_strap};
            fault_sync <= {fault_sync[0], i_loop_fault_live};
            cs_prev    <= cs_sync[1];
        end
    end

    // ----------------------------------------------------------------
    // frame decode at the end of each chip-select window
    // ----------------------------------------------------------------
    function automatic logic addr_is_valid(input logic [6:0] addr);
        addr_is_valid = (addr <= P_MAX_ADDR) || (addr == ldesr_pkg::ADDR_STATUS_ALT);
    endfunction

    function automatic logic addr_is_status(input logic [6:0] addr);
        addr_is_status = (addr == ldesr_pkg::ADDR_STATUS)
                      || (addr == ldesr_pkg::ADDR_STATUS_ALT);
    endfunction

    logic        frame_end;
    logic        frame_good;
    logic        frame_bad;
    logic        frame_read;
    logic        frame_write;
    logic [6:0]  frame_addr;
    logic [15:0] frame_data;
    logic        frame_tog_seen;
    logic        frame_clocked;

    // without this a frame with no clocks would replay the last command
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            frame_tog_seen <= 1'b0;
        else if (frame_end)
            frame_tog_seen <= link_frame_tog;
    end

    // link registers are static here: sclk has stopped with chip select high
    assign frame_end     = cs_sync[1] && !cs_prev;
    assign frame_clocked = (link_frame_tog != frame_tog_seen);
    assign frame_good    = frame_end && frame_clocked && link_word_seen
                        && (link_bit_idx == 5'h00);
    assign frame_bad     = frame_end && (!frame_clocked || (link_bit_idx != 5'h00));
    assign frame_read  = frame_good && link_shift[ldesr_pkg::CMD_READ_BIT];
    assign frame_write = frame_good && !link_shift[ldesr_pkg::CMD_READ_BIT];
    assign frame_addr  = link_shift[ldesr_pkg::ADDR_MSB:ldesr_pkg::ADDR_LSB];
    assign frame_data  = link_shift[ldesr_pkg::DATA_MSB:0];

    // ----------------------------------------------------------------
    // soft reset sequence
    // ----------------------------------------------------------------
    logic reset_armed;
    logic soft_reset;

    assign soft_reset = frame_write && reset_armed && (frame_addr == P_IDLE_ADDR);

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            reset_armed <= 1'b0;
        else if (frame_write)
            reset_armed <= (frame_addr == ldesr_pkg::ADDR_SOFT_RESET)
                        && (frame_data == ldesr_pkg::SOFT_RESET_KEY);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_soft_reset <= 1'b0;
        else
            o_soft_reset <= soft_reset;
    end

    // ----------------------------------------------------------------
    // error level registers
    // ----------------------------------------------------------------
    logic [15:0] upper_error_level;
    logic [15:0] lower_error_level;

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            upper_error_level <= ldesr_pkg::UPPER_ERROR_RESET;
        else if (soft_reset)
            upper_error_level <= ldesr_pkg::UPPER_ERROR_RESET;
        else if (frame_write && (frame_addr == ldesr_pkg::ADDR_UPPER_ERROR)
                 && (frame_data[15:8] >= ldesr_pkg::UPPER_ERROR_MIN))
            upper_error_level <= {frame_data[15:8], ldesr_pkg::ERROR_LOW_BYTE};
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            lower_error_level <= ldesr_pkg::LOWER_ERROR_RESET;
        else if (soft_reset)
            lower_error_level <= ldesr_pkg::LOWER_ERROR_RESET;
        else if (frame_write && (frame_addr == ldesr_pkg::ADDR_LOWER_ERROR)
                 && (frame_data[15:8] <= ldesr_pkg::LOWER_ERROR_MAX))
            lower_error_level <= {frame_data[15:8], ldesr_pkg::ERROR_LOW_BYTE};
    end

    // high select takes priority if both are raised at once
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_converter_code <= 16'h0000;
        else if (i_high_error_select)
            o_converter_code <= {upper_error_level[15:8], ldesr_pkg::ERROR_LOW_BYTE};
        else if (i_low_error_select)
            o_converter_code <= {lower_error_level[15:8], ldesr_pkg::ERROR_LOW_BYTE};
        else
            o_converter_code <= i_output_code;
    end

    // ----------------------------------------------------------------
    // serial timeout
    // ----------------------------------------------------------------
    logic [31:0] step_count;
    logic [3:0]  step_total;
    logic        step_tick;
    logic        timeout_hit;

    assign step_tick   = (step_count == P_STEP_CYCLES - 1);
    assign timeout_hit = step_tick && (step_total == {1'b0, i_timeout_setting});

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            step_count <= 32'h00000000;
            step_total <= 4'h0;
        end
        else if (frame_write)
        begin
            step_count <= 32'h00000000;
            step_total <= 4'h0;
        end
        else if (step_tick)
        begin
            step_count <= 32'h00000000;
            if (!timeout_hit)
                step_total <= step_total + 4'h1;
            else
                step_total <= 4'h0;
        end
        else
        begin
            step_count <= step_count + 32'h00000001;
        end
    end

    // expiry outranks a valid write landing in the same cycle
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_serial_timeout <= 1'b0;
        else if (timeout_hit)
            o_serial_timeout <= 1'b1;
        else if (frame_write && addr_is_valid(frame_addr))
            o_serial_timeout <= 1'b0;
    end

    // ----------------------------------------------------------------
    // sticky flags and status word
    // ----------------------------------------------------------------
    logic        frame_error_sticky;
    logic        loop_fault_sticky;
    logic        status_read;
    logic [15:0] status_word;

    assign status_read = frame_read && addr_is_status(frame_addr);

    assign status_word = {8'h00,
                          ldesr_pkg::RESOLUTION_CODE,
                          strap_sync[1],
                          frame_error_sticky,
                          o_serial_timeout,
                          loop_fault_sticky,
                          fault_sync[1]};

    // set wins over the read clear
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            frame_error_sticky <= 1'b0;
        else if (frame_bad)
            frame_error_sticky <= 1'b1;
        else if (status_read)
            frame_error_sticky <= 1'b0;
    end

    // a fault still present after the read sets the flag on the next cycle
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            loop_fault_sticky <= 1'b0;
        else if (fault_sync[1] && !status_read)
            loop_fault_sticky <= 1'b1;
        else if (status_read)
            loop_fault_sticky <= 1'b0;
    end

    // ----------------------------------------------------------------
    // read-back word for the next frame
    // ----------------------------------------------------------------
    logic [15:0] read_data;

    always_comb
    begin
        read_data = 16'h0000;
        if (addr_is_status(frame_addr))
            read_data = status_word;
        else if (frame_addr == ldesr_pkg::ADDR_UPPER_ERROR)
            read_data = upper_error_level;
        else if (frame_addr == ldesr_pkg::ADDR_LOWER_ERROR)
            read_data = lower_error_level;
    end

    // captured from the pre-clear flags in the same edge as the clear
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            read_word <= 24'h000000;
        else if (frame_read)
            read_word <= {link_shift[23:16], read_data};
        else if (frame_good)
            read_word <= {link_shift[23:16], 16'h0000};
    end

endmodule

// [tb_loop_dac_error_status_regs.sv]
`timescale 1ns/1ps
module tb_loop_dac_error_status_regs;
    localparam int unsigned STEP = 200;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        sclk, cs_n, sdi, sdo, sdo_oe_n, tmo, srst;
    logic        strap = 1'b0;
    logic        loop_live = 1'b0;
    logic        hi_sel = 1'b0;
    logic        lo_sel = 1'b0;
    logic [15:0] out_code = 16'h1234;
    logic [2:0]  tsel = 3'h1;
    logic [15:0] conv;
    logic [23:0] rd;
    int          failures = 0;
    int          checks = 0;
    int          srst_seen = 0;

    always #5 clk = ~clk;
    always @(negedge clk) if (srst === 1'b1) srst_seen++;

    ldesr_host host (.o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_spi_sdi(sdi), .i_spi_sdo(sdo));
    ldesr_top #(.P_STEP_CYCLES(STEP)) uut (
        .i_core_clk(clk), .i_reset_n(reset_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe_n(sdo_oe_n),
        .i_error_level_strap(strap), .i_loop_fault_live(loop_live),
        .i_output_code(out_code), .i_high_error_select(hi_sel),
        .i_low_error_select(lo_sel), .i_timeout_setting(tsel),
        .o_converter_code(conv), .o_serial_timeout(tmo), .o_soft_reset(srst));

    // ----
    // shared helpers
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer(24, {1'b0, a, d}, rd);
    endtask
    // word comes back during the following frame
    task automatic rdreg(input logic [6:0] a, output logic [15:0] d);
        host.xfer(24, {1'b1, a, 16'h0000}, rd);
        host.xfer(24, {1'b1, 7'h00, 16'h0000}, rd);
        d = rd[15:0];
    endtask
    task automatic end_of_test();
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset_status();
        logic [15:0] v, w;
        rdreg(7'h07, v);
        chk(v, 16'hE800, "upper default");
        for (int s = 0; s < 2; s++)
        begin
            cyc(1);
            strap = s[0];
            cyc(4);
            rdreg(7'h09, v);
            rdreg(7'h7F, w);
            chk(v & 16'hFFFB, {8'h00, 3'h7, strap, 4'h0}, "status fixed bits");
            chk(w & 16'hFFFB, {8'h00, 3'h7, strap, 4'h0}, "status alias");
        end
    endtask
    task automatic t_levels();
        logic [15:0] v;
        wr(7'h07, 16'h7F00);
        rdreg(7'h07, v);
        chk(v, 16'hE800, "upper below mid kept");
        wr(7'h07, 16'h8055);
        rdreg(7'h07, v);
        chk(v, 16'h8000, "upper at mid");
        cyc(1);
        hi_sel = 1'b1;
        lo_sel = 1'b1;
        cyc(3);
        chk(conv, 16'h8000, "high level code");
        hi_sel = 1'b0;
        cyc(3);
        chk(conv, 16'h2400, "low level code");
        wr(7'h06, 16'h8100);
        chk(conv, 16'h2400, "low above mid kept");
        wr(7'h06, 16'h8000);
        chk(conv, 16'h8000, "low at mid");
        cyc(1);
        lo_sel = 1'b0;
        cyc(3);
        chk(conv, out_code, "normal code");
    endtask
    task automatic t_soft();
        logic [15:0] v;
        srst_seen = 0;
        wr(7'h08, 16'hC33C);
        wr(7'h07, 16'hA000);
        wr(7'h02, 16'h0000);
        rdreg(7'h07, v);
        chk(v, 16'hA000, "disarmed reset");
        chk(16'(srst_seen), 16'h0000, "no reset pulse");
        cyc(1);
        hi_sel = 1'b1;
        wr(7'h08, 16'hC33C);
        wr(7'h02, 16'h0000);
        chk(conv, 16'hE800, "code after reset");
        rdreg(7'h06, v);
        chk(v, 16'h2400, "lower after reset");
        chk(16'(srst_seen), 16'h0001, "one reset pulse");
        cyc(1);
        hi_sel = 1'b0;
    endtask
    task automatic t_frame();
        logic [15:0] v;
        for (int n = 23; n < 26; n += 2)
        begin
            rdreg(7'h09, v);
            host.xfer(n, {1'b0, 7'h07, 16'h9000}, rd);
            rdreg(7'h09, v);
            chk(v & 16'h0008, 16'h0008, "frame error set");
            rdreg(7'h09, v);
            chk(v & 16'h0008, 16'h0000, "frame error cleared");
            rdreg(7'h07, v);
            chk(v, 16'hE800, "bad frame not written");
        end
    endtask
    task automatic t_loop();
        logic [15:0] v;
        rdreg(7'h09, v);
        cyc(1);
        loop_live = 1'b1;
        cyc(5);
        rdreg(7'h09, v);
        chk(v & 16'h0003, 16'h0003, "loop fault seen");
        rdreg(7'h09, v);
        chk(v & 16'h0003, 16'h0003, "persisting fault resets sticky");
        cyc(1);
        loop_live = 1'b0;
        cyc(5);
        rdreg(7'h09, v);
        chk(v & 16'h0003, 16'h0002, "sticky outlives fault");
        rdreg(7'h09, v);
        chk(v & 16'h0003, 16'h0000, "sticky cleared");
    endtask
    task automatic t_timeout();
        logic [15:0] v;
        for (int t = 0; t < 3; t += 2)
        begin
            cyc(1);
            tsel = 3'(t);
            wr(7'h02, 16'h0000);
            cyc((t + 1) * STEP - 120);
            wr(7'h02, 16'h0000);
            cyc((t + 1) * STEP - 20);
            chk({15'h0, tmo}, 16'h0000, "timer restarted");
            cyc(30);
            chk({15'h0, tmo}, 16'h0001, "timeout raised");
            wr(7'h40, 16'h0000);
            chk({15'h0, tmo}, 16'h0001, "unmapped write keeps flag");
            rdreg(7'h09, v);
            chk(v & 16'h0004, 16'h0004, "timeout in status");
            wr(7'h07, 16'hE800);
            chk({15'h0, tmo}, 16'h0000, "valid write clears");
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        cyc(4);
        t_reset_status();
        t_levels();
        t_soft();
        t_frame();
        t_loop();
        t_timeout();
        end_of_test();
    end
    initial
    begin
        #400us;
        failures++;
        end_of_test();
    end
endmodule
